// ---- dv/flag_unit_asserts.sv ----
// Concurrent checks on the flag unit's bus, stack and flag ports.
`timescale 1ns/1ps
module flag_unit_asserts (
   input wire logic                  sys_clk,
   input wire logic                  reset_n,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [31:0]           s_axi_rdata,
   input flag_unit_pkg::stack_wr_t   stack_wr,
   input wire logic                  cond_true,
   input flag_unit_pkg::flags_t      flags
);
   import flag_unit_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_b_latency: assert property ($fell(s_axi_awready) && $fell(s_axi_wready) |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel open during response");
   a_push_pair: assert property ($rose(stack_wr.we) |=> stack_wr.we ##1 !stack_wr.we)
      else $error("push is not two words");
   a_push_step: assert property ($rose(stack_wr.we) |=> stack_wr.addr[15:0] == $past(stack_wr.addr[15:0]) - 16'h2)
      else $error("second push address wrong");
   // Flags and condition may only move on the edge that commits a write.
   a_flags_quiet: assert property ($changed(flags) |-> $rose(s_axi_bvalid))
      else $error("flags changed without a command");
   a_cond_quiet: assert property ($changed(cond_true) |-> $rose(s_axi_bvalid))
      else $error("condition changed without a command");
   cover property (stack_wr.we ##1 stack_wr.we);
   cover property ($rose(cond_true));
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : flag_unit_asserts

// ---- dv/tb_top.sv ----
// Self-checking bench for the flag unit.
`timescale 1ns/1ps
module tb_top;
   import flag_unit_pkg::*;
   logic        sys_clk = 1'b0, reset_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, cond_true;
   logic [1:0]  bresp, rresp;
   stack_wr_t   stack_wr;
   flags_t      flags;
   stack_wr_t   pushes[$];
   int          n_errors = 0, n_compared = 0;
   flag_unit dut_u (.sys_clk, .reset_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .stack_wr, .cond_true, .flags);
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (stack_wr.we) pushes.push_back(stack_wr);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 50);
      // The response is left waiting one cycle so that it has to stand.
      bready <= 1'b1;
      @(posedge sys_clk);
      bready <= 1'b0;
      chk(bvalid, 32'h1);
      chk(bresp, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 50);
      rready <= 1'b1;
      @(posedge sys_clk);
      rready <= 1'b0;
      chk(rvalid, 32'h1);
      d = rdata;
      chk(rresp, er);
   endtask : rd
   task automatic op(input logic [3:0] o, input logic [1:0] sz);
      wr(ADDR_COMMAND, {26'h0, sz, o});
   endtask : op
   // Expected condition from flags {carry, zero, sign, overflow}.
   function automatic logic cm(input logic [3:0] c, input logic [3:0] f);
      logic r;
      case (c[2:0])
         3'h0: r = 1'b1;
         3'h1: r = f[1] ^ f[0];
         3'h2: r = (f[1] ^ f[0]) | f[2];
         3'h3: r = f[3] | f[2];
         3'h4: r = f[0];
         3'h5: r = f[1];
         3'h6: r = f[2];
         default: r = f[3];
      endcase
      return c[3] ? r : !r;
   endfunction : cm
   task automatic s_cond;
      for (int f = 0; f < 16; f++)
      begin
         wr(ADDR_FLAGS, 32'(f) << 4);
         chk(flags, 32'(f));
         for (int c = 0; c < 16; c++)
         begin
            wr(ADDR_COND_SEL, 32'(c));
            chk(cond_true, cm(c[3:0], f[3:0]));
         end
      end
   endtask : s_cond
   task automatic s_ops;
      logic [31:0] d;
      wr(ADDR_FLAGS, 32'h80);
      wr(ADDR_OPER_A, 32'h80);
      op(OP_TEST, SIZE_BYTE);
      chk(flags, 4'hA);
      wr(ADDR_OPER_A, 32'h0);
      op(OP_TEST, SIZE_BYTE);
      chk(flags, 4'hD);
      wr(ADDR_OPER_A, 32'h8000);
      op(OP_TEST, SIZE_WORD);
      chk(flags, 4'hB);
      wr(ADDR_COND_SEL, COND_UNSIGNED_BELOW);
      wr(ADDR_OPER_A, 32'h3);
      wr(ADDR_OPER_B, 32'h5);
      op(OP_COMPARE, SIZE_BYTE);
      chk(flags, 4'hA);
      chk(cond_true, 32'h1);
      wr(ADDR_OPER_A, 32'h8000_0000);
      wr(ADDR_OPER_B, 32'h1);
      op(OP_COMPARE, 2'h2);
      chk(flags, 4'h1);
      wr(ADDR_FLAGS, 32'h80);
      wr(ADDR_OPER_A, 32'h7F);
      op(OP_INCREMENT, SIZE_BYTE);
      chk(flags, 4'hB);
      rd(ADDR_OPER_A, d);
      chk(d, 32'h80);
      wr(ADDR_OPER_B, 32'hF0);
      op(OP_SET_FLAG, SIZE_BYTE);
      chk(flags, 4'hF);
      wr(ADDR_OPER_B, 32'h90);
      op(OP_RESET_FLAG, SIZE_BYTE);
      chk(flags, 4'h6);
      op(OP_NO_FLAGS, SIZE_WORD);
      op(4'hA, SIZE_WORD);
      chk(flags, 4'h6);
   endtask : s_ops
   task automatic s_trap;
      logic [31:0] d;
      wr(ADDR_SP_SYS, 32'h100);
      wr(ADDR_PC, 32'h1234);
      wr(ADDR_FCW, 32'h60);
      wr(ADDR_FCW, 32'h4060, RESP_SLVERR);
      op(OP_FLAGS_TO_BYTE, SIZE_BYTE);
      rd(ADDR_OPER_A, d);
      chk(d[7:0], 8'h60);
      wr(ADDR_OPER_A, 32'h50);
      op(OP_BYTE_TO_FLAGS, SIZE_BYTE);
      chk(flags, 4'h5);
      pushes.delete();
      op(OP_SYSTEM_CALL, SIZE_WORD);
      repeat (3) @(posedge sys_clk);
      chk(32'(pushes.size()), 32'h2);
      chk(pushes[0].addr, 32'hFE);
      chk(pushes[0].data, 16'h0050);
      chk(pushes[1].data, 16'h1234);
      chk(pushes[1].addr, 32'hFC);
      rd(ADDR_SP_SYS, d);
      chk(d, 32'hFC);
      wr(ADDR_RESTORE, 32'h40A0);
      op(OP_INTERRUPT_RETURN, SIZE_WORD);
      chk(flags, 4'hA);
      rd(ADDR_SP_SYS, d);
      chk(d, 32'h100);
      rd(8'h2C, d, RESP_SLVERR);
   endtask : s_trap
   task automatic end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      chk(flags, 4'h0);
      chk(cond_true, 32'h1);
      s_cond();
      s_ops();
      s_trap();
      end_sim();
   end
   initial
   begin
      #400000;
      n_errors++;
      end_sim();
   end
endmodule : tb_top
bind flag_unit flag_unit_asserts chk_u (.sys_clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .stack_wr, .cond_true, .flags);

// ---- verilog/flag_unit.sv ----
// Flag register, condition evaluator and flag-updating operations behind AXI4-Lite.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module flag_unit #(
   parameter int ADDR_W = 8
) (
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output flag_unit_pkg::stack_wr_t      stack_wr,
   output logic                          cond_true,
   output flag_unit_pkg::flags_t         flags
);
   import flag_unit_pkg::*;

   typedef enum {ST_IDLE, ST_PUSH_FCW, ST_PUSH_PC} state_t;

   state_t            state_reg;
   state_t            state_next;
   logic              aw_full_reg;
   logic              w_full_reg;
   logic [7:0]        aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic [15:0]       fcw_reg;
   logic [15:0]       fcw_next;
   logic [31:0]       oper_a_reg;
   logic [31:0]       oper_a_next;
   logic [31:0]       oper_b_reg;
   logic [31:0]       command_reg;
   logic [31:0]       sp_sys_reg;
   logic [31:0]       sp_sys_next;
   logic [31:0]       sp_nrm_reg;
   logic [31:0]       pc_reg;
   logic [31:0]       restore_reg;
   logic [3:0]        cond_sel_reg;
   logic [3:0]        cond_sel_next;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic [31:0] fit(input logic [31:0] x, input logic [1:0] sz);
      fit = (sz == SIZE_BYTE) ? {24'h0, x[7:0]} :
            (sz == SIZE_WORD) ? {16'h0, x[15:0]} : x;
   endfunction : fit

   function automatic logic top_bit(input logic [31:0] x, input logic [1:0] sz);
      top_bit = (sz == SIZE_BYTE) ? x[7] : (sz == SIZE_WORD) ? x[15] : x[31];
   endfunction : top_bit

   // Synonyms share one code, so they cannot decode differently.
   function automatic logic eval_cond(input flags_t f, input logic [3:0] code);
      logic t;
      unique case (code[2:0])
         3'h0: t = 1'b1;
         3'h1: t = f.sign ^ f.overflow;
         3'h2: t = (f.sign ^ f.overflow) | f.zero;
         3'h3: t = f.carry | f.zero;
         3'h4: t = f.overflow;
         3'h5: t = f.sign;
         3'h6: t = f.zero;
         3'h7: t = f.carry;
      endcase
      eval_cond = code[3] ? t : ~t;
   endfunction : eval_cond

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = val[i*8 +: 8];
      merge = r;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= ADDR_COND_SEL);
   endfunction : mapped

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      unique case (a)
         ADDR_FLAGS:    reg_read = {24'h0, fcw_reg[7:FLAG_LSB], 4'h0};
         ADDR_OPER_A:   reg_read = oper_a_reg;
         ADDR_OPER_B:   reg_read = oper_b_reg;
         ADDR_COMMAND:  reg_read = command_reg;
         ADDR_STATUS:   reg_read = {24'h0, fcw_reg[7:FLAG_LSB], 2'h0,
                                    state_reg != ST_IDLE, cond_true};
         ADDR_FCW:      reg_read = {16'h0, fcw_reg};
         ADDR_SP_SYS:   reg_read = sp_sys_reg;
         ADDR_SP_NRM:   reg_read = sp_nrm_reg;
         ADDR_PC:       reg_read = pc_reg;
         ADDR_RESTORE:  reg_read = restore_reg;
         ADDR_COND_SEL: reg_read = {28'h0, cond_sel_reg};
         default:       reg_read = 32'h0000_0000;
      endcase
   endfunction : reg_read

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   // A write is held back while a system call is pushing, so a command can
   // never collide with the stack sequence.
   wire         sys_mode  = fcw_reg[FCW_SYS_BIT];
   wire         wr_ready  = aw_full_reg & w_full_reg & ~s_axi_bvalid & (state_reg == ST_IDLE);
   wire         privileged = (aw_addr_reg == ADDR_FCW) | (aw_addr_reg == ADDR_SP_SYS);
   wire         refused   = ~mapped(aw_addr_reg) | (~sys_mode & privileged);
   wire         do_write  = wr_ready & ~refused;
   wire  [31:0] wr_val    = merge(reg_read(aw_addr_reg), w_data_reg, w_strb_reg);
   wire         hit_flags = do_write & (aw_addr_reg == ADDR_FLAGS);
   wire         hit_cmd   = do_write & (aw_addr_reg == ADDR_COMMAND);
   wire         hit_fcw   = do_write & (aw_addr_reg == ADDR_FCW);
   wire         hit_a     = do_write & (aw_addr_reg == ADDR_OPER_A);
   wire         hit_b     = do_write & (aw_addr_reg == ADDR_OPER_B);
   wire         hit_sps   = do_write & (aw_addr_reg == ADDR_SP_SYS);
   wire         hit_spn   = do_write & (aw_addr_reg == ADDR_SP_NRM);
   wire         hit_pc    = do_write & (aw_addr_reg == ADDR_PC);
   wire         hit_rst   = do_write & (aw_addr_reg == ADDR_RESTORE);
   wire         hit_cond  = do_write & (aw_addr_reg == ADDR_COND_SEL);
   wire  [3:0]  cmd_op    = wr_val[3:0];
   wire  [1:0]  cmd_size  = wr_val[CMD_SIZE_LSB +: 2];

   // ------------------------------------------------------------
   // Flag arithmetic
   // ------------------------------------------------------------
   wire  [31:0] a_fit     = fit(oper_a_reg, cmd_size);
   wire  [31:0] b_fit     = fit(oper_b_reg, cmd_size);
   wire         a_top     = top_bit(a_fit, cmd_size);
   wire         b_top     = top_bit(b_fit, cmd_size);
   wire  [32:0] diff      = {1'b0, a_fit} - {1'b0, b_fit};
   wire  [31:0] sum       = fit(a_fit + b_fit, cmd_size);
   wire         diff_top  = top_bit(diff[31:0], cmd_size);
   wire         sum_top   = top_bit(sum, cmd_size);
   flags_t      cur_flags;
   flags_t      cmp_flags;
   flags_t      new_flags;

   assign cur_flags = flags_t'(fcw_reg[7:FLAG_LSB]);
   // Zero-extended operands make bit 32 the borrow at every size.
   assign cmp_flags = '{carry:    diff[32],
                        zero:     fit(diff[31:0], cmd_size) == 32'h0,
                        sign:     diff_top,
                        overflow: (a_top != b_top) && (diff_top != a_top)};

   always_comb
   begin
      new_flags = cur_flags;
      unique case (op_t'(cmd_op))
         OP_TEST:
         begin
            new_flags.sign = a_top;
            new_flags.zero = (a_fit == 32'h0);
            if (cmd_size == SIZE_BYTE)
               new_flags.overflow = ~^a_fit[7:0];
         end
         OP_COMPARE: new_flags = cmp_flags;
         OP_INCREMENT:
         begin
            new_flags.zero     = (sum == 32'h0);
            new_flags.sign     = sum_top;
            new_flags.overflow = (a_top == b_top) && (sum_top != a_top);
         end
         OP_SET_FLAG:      new_flags = cur_flags | flags_t'(oper_b_reg[7:FLAG_LSB]);
         OP_RESET_FLAG:    new_flags = cur_flags & ~flags_t'(oper_b_reg[7:FLAG_LSB]);
         OP_BYTE_TO_FLAGS: new_flags = flags_t'(oper_a_reg[7:FLAG_LSB]);
         default:          new_flags = cur_flags;
      endcase
   end

   // ------------------------------------------------------------
   // Next-state logic of the architectural registers
   // ------------------------------------------------------------
   always_comb
   begin
      fcw_next      = fcw_reg;
      oper_a_next   = oper_a_reg;
      sp_sys_next   = sp_sys_reg;
      cond_sel_next = cond_sel_reg;
      state_next    = state_reg;
      if (hit_flags)
         fcw_next[7:FLAG_LSB] = wr_val[7:FLAG_LSB];
      if (hit_fcw)
         fcw_next = wr_val[15:0];
      if (hit_a)
         oper_a_next = wr_val;
      if (hit_sps)
         sp_sys_next = wr_val;
      if (hit_cond)
         cond_sel_next = wr_val[3:0];
      if (hit_cmd)
      begin
         fcw_next[7:FLAG_LSB] = new_flags;
         if (op_t'(cmd_op) == OP_INCREMENT)
            oper_a_next = sum;
         if (op_t'(cmd_op) == OP_FLAGS_TO_BYTE)
            oper_a_next = {oper_a_reg[31:8], fcw_reg[7:FLAG_LSB], 4'h0};
         if (op_t'(cmd_op) == OP_SYSTEM_CALL)
            state_next = ST_PUSH_FCW;
         if (op_t'(cmd_op) == OP_INTERRUPT_RETURN)
         begin
            fcw_next    = restore_reg[15:0];
            sp_sys_next = {sp_sys_reg[31:16], sp_sys_reg[15:0] + STACK_SLOT + STACK_SLOT};
         end
      end
      unique case (state_reg)
         ST_IDLE:
         begin
         end
         ST_PUSH_FCW: state_next = ST_PUSH_PC;
         ST_PUSH_PC:
         begin
            // Only the offset half moves, so a segmented pair keeps its segment.
            sp_sys_next = {sp_sys_reg[31:16], sp_sys_reg[15:0] - STACK_SLOT - STACK_SLOT};
            fcw_next[FCW_SYS_BIT] = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Register file and trap sequencer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_reg    <= ST_IDLE;
         fcw_reg      <= FCW_RESET;
         oper_a_reg   <= WORD_RESET;
         oper_b_reg   <= WORD_RESET;
         command_reg  <= WORD_RESET;
         sp_sys_reg   <= WORD_RESET;
         sp_nrm_reg   <= WORD_RESET;
         pc_reg       <= WORD_RESET;
         restore_reg  <= WORD_RESET;
         cond_sel_reg <= COND_RESET;
         cond_true    <= 1'b1;
         flags        <= '0;
         stack_wr     <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         fcw_reg      <= fcw_next;
         oper_a_reg   <= oper_a_next;
         sp_sys_reg   <= sp_sys_next;
         cond_sel_reg <= cond_sel_next;
         // Evaluated on the next flags so the output never lags them.
         cond_true    <= eval_cond(flags_t'(fcw_next[7:FLAG_LSB]), cond_sel_next);
         flags        <= flags_t'(fcw_next[7:FLAG_LSB]);
         stack_wr.we  <= 1'b0;
         if (hit_b)
            oper_b_reg <= wr_val;
         if (hit_cmd)
            command_reg <= wr_val;
         if (hit_spn)
            sp_nrm_reg <= wr_val;
         if (hit_pc)
            pc_reg <= wr_val;
         if (hit_rst)
            restore_reg <= wr_val;
         if (state_reg == ST_PUSH_FCW)
         begin
            stack_wr <= '{we: 1'b1, data: fcw_reg,
                          addr: {sp_sys_reg[31:16], sp_sys_reg[15:0] - STACK_SLOT}};
         end
         if (state_reg == ST_PUSH_PC)
         begin
            stack_wr <= '{we: 1'b1, data: pc_reg[15:0],
                          addr: {sp_sys_reg[31:16], sp_sys_reg[15:0] - STACK_SLOT - STACK_SLOT}};
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channels
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= WORD_RESET;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= 8'(s_axi_awaddr);
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_ready)
         begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= refused ? RESP_SLVERR : RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channels
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= WORD_RESET;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= reg_read(8'(s_axi_araddr));
            s_axi_rresp   <= mapped(8'(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule : flag_unit

// ---- verilog/flag_unit_pkg.sv ----
// Constants and types shared by the flag and condition-code unit.
package flag_unit_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAGS    = 8'h00;
   localparam logic [7:0] ADDR_OPER_A   = 8'h04;
   localparam logic [7:0] ADDR_OPER_B   = 8'h08;
   localparam logic [7:0] ADDR_COMMAND  = 8'h0C;
   localparam logic [7:0] ADDR_STATUS   = 8'h10;
   localparam logic [7:0] ADDR_FCW      = 8'h14;
   localparam logic [7:0] ADDR_SP_SYS   = 8'h18;
   localparam logic [7:0] ADDR_SP_NRM   = 8'h1C;
   localparam logic [7:0] ADDR_PC       = 8'h20;
   localparam logic [7:0] ADDR_RESTORE  = 8'h24;
   localparam logic [7:0] ADDR_COND_SEL = 8'h28;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam int          FCW_SYS_BIT   = 14;
   localparam int          FCW_SEG_BIT   = 15;
   localparam int          FLAG_LSB      = 4;
   localparam int          CMD_SIZE_LSB  = 4;
   localparam logic [15:0] FCW_RESET     = 16'h4000;
   localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
   localparam logic [3:0]  COND_RESET    = 4'h8;
   localparam logic [15:0] STACK_SLOT    = 16'h0002;
   localparam logic [1:0]  SIZE_BYTE     = 2'h0;
   localparam logic [1:0]  SIZE_WORD     = 2'h1;

   // ------------------------------------------------------------
   // Condition codes; bit 3 selects the true form
   // ------------------------------------------------------------
   localparam logic [3:0] COND_NEVER                = 4'h0;
   localparam logic [3:0] COND_SIGNED_GREATER_EQUAL = 4'h1;
   localparam logic [3:0] COND_SIGNED_GREATER       = 4'h2;
   localparam logic [3:0] COND_UNSIGNED_ABOVE       = 4'h3;
   localparam logic [3:0] COND_NO_OVERFLOW          = 4'h4;
   localparam logic [3:0] COND_PARITY_ODD           = 4'h4;
   localparam logic [3:0] COND_POSITIVE             = 4'h5;
   localparam logic [3:0] COND_NONZERO              = 4'h6;
   localparam logic [3:0] COND_NOT_EQUAL            = 4'h6;
   localparam logic [3:0] COND_UNSIGNED_NOT_BELOW   = 4'h7;
   localparam logic [3:0] COND_ALWAYS               = 4'h8;
   localparam logic [3:0] COND_SIGNED_LESS          = 4'h9;
   localparam logic [3:0] COND_SIGNED_LESS_EQUAL    = 4'hA;
   localparam logic [3:0] COND_UNSIGNED_BELOW_EQUAL = 4'hB;
   localparam logic [3:0] COND_OVERFLOWED           = 4'hC;
   localparam logic [3:0] COND_PARITY_EVEN          = 4'hC;
   localparam logic [3:0] COND_NEGATIVE             = 4'hD;
   localparam logic [3:0] COND_EQUAL                = 4'hE;
   localparam logic [3:0] COND_UNSIGNED_BELOW       = 4'hF;

   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic overflow;
   } flags_t;

   typedef enum logic [3:0] {
      OP_NO_FLAGS,
      OP_TEST,
      OP_COMPARE,
      OP_INCREMENT,
      OP_SET_FLAG,
      OP_RESET_FLAG,
      OP_SYSTEM_CALL,
      OP_INTERRUPT_RETURN,
      OP_FLAGS_TO_BYTE,
      OP_BYTE_TO_FLAGS
   } op_t;

   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [15:0] data;
   } stack_wr_t;

endpackage : flag_unit_pkg
